// ### rtl/cgw_gateway.sv
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module cgw_gateway (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// node a events
	input wire logic a_data_rx,
	input wire logic a_remote_rx,
	input wire logic a_tx_done,
	// node b events
	input wire logic b_data_rx,
	input wire logic b_remote_rx,
	input wire logic b_tx_done,
	// received frame contents
	input wire logic [cgw_pkg::ID_W-1:0] rx_identifier,
	input wire logic [cgw_pkg::DLC_W-1:0] rx_length,
	input wire logic [cgw_pkg::DATA_W-1:0] rx_data,
	// fifo copy strobe
	output logic fifo_copy,
	output logic [cgw_pkg::OBJ_W-1:0] fifo_copy_obj,
	output logic fifo_copy_transmit_request,
	// shared object transmit
	output logic tx_req_a,
	output logic tx_req_b,
	output logic tx_remote,
	output logic [cgw_pkg::ID_W-1:0] tx_identifier,
	output logic [cgw_pkg::DLC_W-1:0] tx_length,
	output logic [cgw_pkg::DATA_W-1:0] tx_data,
	output logic irq_pending
);
	import cgw_pkg::*;

	typedef struct packed {
		logic [31:0] src_ctrl;
		logic [OBJ_W-1:0] src_ptr;
		logic [31:0] sh_ctrl;
		cgw_state_e state;
		logic transmit_request;
		logic remote_pending;
		logic new_data_flag;
		logic interrupt_pending;
		logic lost;
		logic cpu_lock;
		logic copy;
		logic [OBJ_W-1:0] copy_obj;
		logic copy_transmit_request;
		logic [ID_W-1:0] id;
		logic [DLC_W-1:0] dlc;
		logic [DATA_W-1:0] data;
		logic [31:0] rdata;
	} cgw_state_s;

	cgw_state_s r;
	cgw_state_s next_r;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [OBJ_W-1:0] fifo_step(input logic [OBJ_W-1:0] ptr,
		input logic [SIZE_W-1:0] len);
		logic [OBJ_W-1:0] msk;
		msk = len - 5'h1;
		fifo_step = (ptr & ~msk) | ((ptr + 5'h1) & msk);
	endfunction

	function automatic logic two_bit(input logic [1:0] f, input logic cur);
		if (f == FLD_SET) begin
			two_bit = 1'b1;
		end else if (f == FLD_RESET) begin
			two_bit = 1'b0;
		end else begin
			two_bit = cur;
		end
	endfunction

	logic sh_on, side, auto_tx, rfwd;
	logic src_data, dst_remote, src_txdone, dst_txdone;
	assign sh_on = r.sh_ctrl[F_MODE +: 3] == MODE_SHARED;
	assign side = r.sh_ctrl[F_SIDE];
	assign auto_tx = r.sh_ctrl[F_AUTO];
	assign rfwd = r.sh_ctrl[F_RFWD];
	assign src_data = side ? b_data_rx : a_data_rx;
	assign dst_remote = side ? a_remote_rx : b_remote_rx;
	assign src_txdone = side ? b_tx_done : a_tx_done;
	assign dst_txdone = side ? a_tx_done : b_tx_done;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.copy = 1'b0;
		next_r.rdata = 32'h0;
		// register writes
		if (reg_write) begin
			if (reg_addr == REG_SRC_CTRL) begin
				next_r.src_ctrl = reg_wdata;
			end else if (reg_addr == REG_SRC_PTR) begin
				next_r.src_ptr = reg_wdata[OBJ_W-1:0];
			end else if (reg_addr == REG_SH_CTRL) begin
				next_r.sh_ctrl = reg_wdata;
				next_r.cpu_lock = two_bit(reg_wdata[F_CPUW +: 2], r.cpu_lock);
				next_r.lost = two_bit(reg_wdata[F_LOSTW +: 2], r.lost);
				next_r.transmit_request = two_bit(reg_wdata[F_CPUW+8 +: 2], r.transmit_request);
				if (reg_wdata[F_CPUW+10 +: 2] == FLD_RESET) begin
					next_r.interrupt_pending = 1'b0;
				end
			end
		end
		// only data frames copied, remotes stay local
		if ((r.src_ctrl[F_MODE +: 3] & MODE_FIFO_MASK) == MODE_FIFO_GW && a_data_rx) begin
			next_r.copy = 1'b1;
			next_r.copy_obj = r.src_ptr;
			next_r.copy_transmit_request = r.src_ctrl[F_AUTO];
			next_r.src_ptr = fifo_step(r.src_ptr, r.src_ctrl[F_SIZE +: SIZE_W]);
		end
		if (sh_on) begin
			case (r.state)
				CGW_SRC_RX: begin
					if (src_data) begin
						next_r.id = rx_identifier;
						next_r.dlc = rx_length;
						next_r.data = rx_data;
						next_r.new_data_flag = 1'b1;
						next_r.remote_pending = 1'b0;
						next_r.interrupt_pending = r.interrupt_pending | r.sh_ctrl[F_RECEIVE_IRQ_ENABLE];
						// lost turns into cpu update lock
						next_r.cpu_lock = r.lost | r.cpu_lock;
						next_r.lost = 1'b0;
						// auto-transmit, held off by the lock
						if (auto_tx) begin
							next_r.transmit_request = 1'b1;
							next_r.state = CGW_DST_TX;
						end else begin
							next_r.transmit_request = 1'b0;
							next_r.state = CGW_DST_WAIT;
						end
					end
				end
				CGW_DST_TX, CGW_DST_WAIT: begin
					if (dst_txdone && r.transmit_request) begin
						next_r.transmit_request = 1'b0;
						next_r.remote_pending = 1'b0;
						next_r.new_data_flag = 1'b0;
						next_r.interrupt_pending = r.interrupt_pending | r.sh_ctrl[F_TRANSMIT_IRQ_ENABLE];
						next_r.state = rfwd ? CGW_DST_WAIT : CGW_SRC_RX;
					end else if (dst_remote) begin
						next_r.interrupt_pending = r.interrupt_pending | r.sh_ctrl[F_RECEIVE_IRQ_ENABLE];
						if (rfwd) begin
							next_r.transmit_request = 1'b1;
							next_r.remote_pending = 1'b1;
							next_r.state = CGW_SRC_RMT;
						end else begin
							next_r.transmit_request = 1'b1;
							next_r.remote_pending = 1'b1;
							next_r.new_data_flag = 1'b0;
							next_r.state = CGW_DST_TX;
						end
					end else if (r.transmit_request) begin
						next_r.state = CGW_DST_TX;
					end
				end
				CGW_SRC_RMT: begin
					if (src_txdone) begin
						next_r.transmit_request = 1'b0;
						next_r.remote_pending = 1'b0;
						next_r.interrupt_pending = r.interrupt_pending | r.sh_ctrl[F_TRANSMIT_IRQ_ENABLE];
						next_r.state = CGW_SRC_RX;
					end
				end
				default: next_r.state = CGW_SRC_RX;
			endcase
			// frames on unassigned side ignored, no lost flag
		end else begin
			next_r.state = CGW_SRC_RX;
		end
		// register reads
		if (reg_read) begin
			if (reg_addr == REG_SRC_CTRL) begin
				next_r.rdata = r.src_ctrl;
			end else if (reg_addr == REG_SRC_PTR) begin
				next_r.rdata = {27'h0, r.src_ptr};
			end else if (reg_addr == REG_SH_CTRL) begin
				next_r.rdata = r.sh_ctrl;
			end else if (reg_addr == REG_SH_STAT) begin
				next_r.rdata = {24'h0, r.cpu_lock, r.lost, r.interrupt_pending, r.new_data_flag,
					r.remote_pending, r.transmit_request, r.state};
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			r <= '0;
			r.src_ctrl <= SRC_CTRL_RST;
			r.sh_ctrl <= SH_CTRL_RST;
			r.state <= CGW_SRC_RX;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic send;
	// cpu update lock holds data transmission
	assign send = sh_on && r.transmit_request && ((r.state == CGW_DST_TX && !r.cpu_lock)
		|| r.state == CGW_SRC_RMT);
	assign tx_remote = r.state == CGW_SRC_RMT;
	assign tx_req_a = send && (tx_remote ? !side : side);
	assign tx_req_b = send && (tx_remote ? side : !side);
	assign tx_identifier = r.id;
	assign tx_length = r.dlc;
	assign tx_data = r.data;
	assign irq_pending = r.interrupt_pending;
	assign fifo_copy = r.copy;
	assign fifo_copy_obj = r.copy_obj;
	assign fifo_copy_transmit_request = r.copy_transmit_request;
	assign reg_rdata = r.rdata;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_fifo_advance: assert property (@(posedge sys_clk) disable iff (reset)
		r.copy |-> r.src_ptr == fifo_step(r.copy_obj, r.src_ctrl[F_SIZE +: SIZE_W])
		|| $past(reg_write))
		else $error("fifo pointer not advanced");
	a_fifo_wrap: assert property (@(posedge sys_clk) disable iff (reset)
		r.copy |-> ((r.src_ptr ^ r.copy_obj) & ~(r.src_ctrl[F_SIZE +: SIZE_W] - 5'h1)) == 0
		|| $past(reg_write))
		else $error("fifo pointer left range");
	a_fifo_transmit_request: assert property (@(posedge sys_clk) disable iff (reset)
		r.copy |-> r.copy_transmit_request == $past(r.src_ctrl[F_AUTO]))
		else $error("fifo transmit_request wrong");
	a_fifo_ptr_use: assert property (@(posedge sys_clk) disable iff (reset)
		r.copy |-> r.copy_obj == $past(r.src_ptr))
		else $error("wrong fifo element");
	a_shared_auto: assert property (@(posedge sys_clk) disable iff (reset)
		(sh_on && r.state == CGW_SRC_RX && src_data && auto_tx && !r.lost && !reg_write)
		|=> r.state == CGW_DST_TX && r.transmit_request)
		else $error("no auto transmit");
	a_shared_lost: assert property (@(posedge sys_clk) disable iff (reset)
		(sh_on && r.state == CGW_SRC_RX && src_data && r.lost && !reg_write)
		|=> r.cpu_lock && !r.lost && !tx_req_a && !tx_req_b)
		else $error("lost did not block");
	a_shared_return: assert property (@(posedge sys_clk) disable iff (reset)
		(sh_on && r.state == CGW_DST_TX && dst_txdone && r.transmit_request)
		|=> r.state == (rfwd ? CGW_DST_WAIT : CGW_SRC_RX) && !r.new_data_flag)
		else $error("bad return after tx");
	a_shared_remote: assert property (@(posedge sys_clk) disable iff (reset)
		(sh_on && r.state == CGW_DST_WAIT && dst_remote && rfwd && !dst_txdone)
		|=> r.state == CGW_SRC_RMT ##0 tx_remote)
		else $error("remote not forwarded");
	a_shared_answer: assert property (@(posedge sys_clk) disable iff (reset)
		(sh_on && r.state == CGW_DST_WAIT && dst_remote && !rfwd && !reg_write)
		|=> r.state == CGW_DST_TX && r.transmit_request && r.remote_pending)
		else $error("remote not answered");
	a_unassigned_drop: assert property (@(posedge sys_clk) disable iff (reset)
		(sh_on && (r.state == CGW_DST_TX || r.state == CGW_DST_WAIT) && src_data && !reg_write)
		|=> $stable(r.data) && $stable(r.id) && $stable(r.lost))
		else $error("frame taken on unassigned side");
	a_side_source: assert property (@(posedge sys_clk) disable iff (reset)
		(sh_on && r.state == CGW_SRC_RX && (side ? b_data_rx : a_data_rx))
		|=> r.state == CGW_DST_TX || r.state == CGW_DST_WAIT)
		else $error("source node not taken");
	a_side_dest: assert property (@(posedge sys_clk) disable iff (reset)
		(send && !tx_remote) |-> (side ? (tx_req_a && !tx_req_b) : (tx_req_b && !tx_req_a)))
		else $error("data sent on wrong node");
	a_tx_clear: assert property (@(posedge sys_clk) disable iff (reset)
		(sh_on && r.state == CGW_DST_TX && dst_txdone && r.transmit_request && !reg_write)
		|=> !r.transmit_request && !r.remote_pending && (r.interrupt_pending || !$past(r.sh_ctrl[F_TRANSMIT_IRQ_ENABLE])))
		else $error("flags not reset after tx");
	a_rx_store: assert property (@(posedge sys_clk) disable iff (reset)
		(sh_on && r.state == CGW_SRC_RX && src_data && !reg_write)
		|=> r.new_data_flag && !r.remote_pending && r.data == $past(rx_data)
		&& r.id == $past(rx_identifier))
		else $error("received frame not stored");
	a_lock_hold: assert property (@(posedge sys_clk) disable iff (reset)
		(r.cpu_lock && r.state == CGW_DST_TX) |-> !tx_req_a && !tx_req_b)
		else $error("locked object transmitted");
	a_fifo_data_only: assert property (@(posedge sys_clk) disable iff (reset)
		!a_data_rx |=> !r.copy)
		else $error("copy without data frame");
	a_fifo_hold: assert property (@(posedge sys_clk) disable iff (reset)
		(!a_data_rx && !reg_write) |=> $stable(r.src_ptr))
		else $error("fifo pointer moved");
	a_rmt_done: assert property (@(posedge sys_clk) disable iff (reset)
		(sh_on && r.state == CGW_SRC_RMT && src_txdone && !reg_write)
		|=> r.state == CGW_SRC_RX && !r.transmit_request && !r.remote_pending)
		else $error("remote not finished");
	a_answer_data: assert property (@(posedge sys_clk) disable iff (reset)
		(sh_on && r.state == CGW_DST_WAIT && dst_remote && !rfwd) |=> $stable(r.data))
		else $error("answer data changed");
	a_wait_hold: assert property (@(posedge sys_clk) disable iff (reset)
		(sh_on && r.state == CGW_DST_WAIT && !r.transmit_request && !dst_remote && !reg_write)
		|=> r.state == CGW_DST_WAIT)
		else $error("wait left without request");
	c_fifo_copy: cover property (@(posedge sys_clk) r.copy);
	c_shared_fwd: cover property (@(posedge sys_clk) r.state == CGW_SRC_RMT);
	c_shared_lock: cover property (@(posedge sys_clk) r.cpu_lock && r.state == CGW_DST_TX);
	c_shared_answer: cover property (@(posedge sys_clk) r.remote_pending && r.state == CGW_DST_TX);
	c_shared_loop: cover property (@(posedge sys_clk)
		r.state == CGW_DST_TX ##[1:20] r.state == CGW_SRC_RX);
endmodule // cgw_gateway

// ### rtl/cgw_pkg.sv
package cgw_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int OBJ_W = 5;
	localparam int SIZE_W = 5;
	localparam int DLC_W = 4;
	localparam int ID_W = 29;
	localparam int DATA_W = 64;
	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_FIFO_GW = 3'h2;
	localparam logic [2:0] MODE_FIFO_MASK = 3'h6;
	localparam logic [2:0] MODE_SHARED = 3'h5;
	localparam logic [1:0] FLD_SET = 2'h2;
	localparam logic [1:0] FLD_RESET = 2'h1;
	localparam logic [1:0] FLD_KEEP = 2'h0;
	// ------------------------------------------------------------
	// register offsets (index = byte address)
	// ------------------------------------------------------------
	localparam logic [3:0] REG_SRC_CTRL = 4'h0;
	localparam logic [3:0] REG_SRC_PTR = 4'h4;
	localparam logic [3:0] REG_SH_CTRL = 4'h8;
	localparam logic [3:0] REG_SH_STAT = 4'hc;
	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int F_MODE = 0;
	localparam int F_AUTO = 3;
	localparam int F_SIZE = 4;
	localparam int F_RFWD = 9;
	localparam int F_SIDE = 10;
	localparam int F_CPUW = 12;
	localparam int F_TRANSMIT_IRQ_ENABLE = 14;
	localparam int F_RECEIVE_IRQ_ENABLE = 16;
	localparam int F_LOSTW = 18;
	localparam logic [31:0] SRC_CTRL_RST = 32'h0;
	localparam logic [31:0] SH_CTRL_RST = 32'h0;
	typedef enum logic [1:0] {CGW_SRC_RX, CGW_DST_TX, CGW_DST_WAIT, CGW_SRC_RMT} cgw_state_e;
endpackage

// ### test/cgw_node_model.sv
`timescale 1ns/100ps
module cgw_node_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// requests and pace
	input wire logic tx_req_a,
	input wire logic tx_req_b,
	input wire logic [7:0] delay,
	// completions
	output logic a_tx_done,
	output logic b_tx_done
);
	typedef struct packed {
		logic [7:0] cnt_a;
		logic [7:0] cnt_b;
		logic done_a;
		logic done_b;
	} cgw_node_s;
	cgw_node_s st;
	cgw_node_s next_st;
	always_comb begin
		next_st = st;
		next_st.done_a = 1'h0;
		next_st.done_b = 1'h0;
		next_st.cnt_a = tx_req_a && !st.done_a ? st.cnt_a + 8'h1 : 8'h0;
		next_st.cnt_b = tx_req_b && !st.done_b ? st.cnt_b + 8'h1 : 8'h0;
		if (tx_req_a && !st.done_a && st.cnt_a >= delay) begin
			next_st.done_a = 1'h1;
			next_st.cnt_a = 8'h0;
		end
		if (tx_req_b && !st.done_b && st.cnt_b >= delay) begin
			next_st.done_b = 1'h1;
			next_st.cnt_b = 8'h0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign a_tx_done = st.done_a;
	assign b_tx_done = st.done_b;
endmodule // cgw_node_model

// ### test/tb.sv
`timescale 1ns/100ps
module tb;
	import cgw_pkg::*;
	logic sys_clk = 1'h0;
	logic reset = 1'h1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'h0;
	logic reg_read = 1'h0;
	logic [31:0] reg_rdata;
	logic [3:0] evt = 4'h0;
	logic a_tx_done, b_tx_done;
	logic [ID_W-1:0] rx_identifier = '0;
	logic [DLC_W-1:0] rx_length = 4'h0;
	logic [DATA_W-1:0] rx_data = '0;
	logic fifo_copy, fifo_copy_transmit_request, tx_req_a, tx_req_b, tx_remote, irq_pending;
	logic [OBJ_W-1:0] fifo_copy_obj;
	logic [ID_W-1:0] tx_identifier;
	logic [DLC_W-1:0] tx_length;
	logic [DATA_W-1:0] tx_data;
	logic [7:0] dly = 8'h3;
	logic [31:0] d;
	int err_count = 0;
	int checks_done = 0;
	cgw_gateway cgw_gateway_i (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .a_data_rx(evt[0]), .a_remote_rx(evt[1]),
		.a_tx_done(a_tx_done), .b_data_rx(evt[2]), .b_remote_rx(evt[3]),
		.b_tx_done(b_tx_done), .rx_identifier(rx_identifier), .rx_length(rx_length),
		.rx_data(rx_data), .fifo_copy(fifo_copy), .fifo_copy_obj(fifo_copy_obj),
		.fifo_copy_transmit_request(fifo_copy_transmit_request), .tx_req_a(tx_req_a), .tx_req_b(tx_req_b),
		.tx_remote(tx_remote), .tx_identifier(tx_identifier), .tx_length(tx_length),
		.tx_data(tx_data), .irq_pending(irq_pending));
	cgw_node_model cgw_node_model_i (.sys_clk(sys_clk), .reset(reset), .tx_req_a(tx_req_a),
		.tx_req_b(tx_req_b), .delay(dly), .a_tx_done(a_tx_done), .b_tx_done(b_tx_done));
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'h1;
		@(posedge sys_clk);
		reg_write <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge sys_clk);
		reg_read <= 1'h0;
		#1 d = reg_rdata;
	endtask
	task automatic ev(input int k, input logic [ID_W-1:0] id);
		@(posedge sys_clk);
		rx_identifier <= id;
		rx_length <= 4'h8;
		rx_data <= {35'h0, id};
		evt <= 4'(4'h1 << k);
		@(posedge sys_clk);
		evt <= 4'h0;
		#1;
	endtask
	task automatic idle_state(input logic [1:0] s);
		for (int n = 0; n < 300 && (tx_req_a || tx_req_b); n++) begin
			@(posedge sys_clk);
			#1;
		end
		chk("tx_idle", tx_req_a | tx_req_b, 1'h0);
		rd(REG_SH_STAT);
		chk("state", d[1:0], s);
	endtask
	task automatic rst;
		@(posedge sys_clk);
		reset <= 1'h1;
		repeat (20) @(posedge sys_clk);
		reset <= 1'h0;
	endtask
	task report_and_stop;
		if (err_count == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_fifo;
		wr(REG_SRC_PTR, 32'h8);
		wr(REG_SRC_CTRL, 32'h4b);
		for (int i = 0; i < 5; i++) begin
			ev(0, 29'(i));
			chk("fifo_copy", fifo_copy, 1'h1);
			chk("copy_obj", fifo_copy_obj, 5'h8 + 5'(i % 4));
			chk("copy_transmit_request", fifo_copy_transmit_request, 1'h1);
		end
		ev(1, 29'h9);
		chk("fifo_remote", fifo_copy, 1'h0);
		rd(REG_SRC_PTR);
		chk("src_ptr", d[4:0], 5'h9);
		wr(REG_SRC_CTRL, 32'h42);
		ev(0, 29'h7);
		chk("copy_obj", fifo_copy_obj, 5'h9);
		chk("copy_transmit_request", fifo_copy_transmit_request, 1'h0);
		rd(4'h1);
		chk("unmapped", d, 32'h0);
	endtask
	task automatic t_auto;
		rst();
		dly <= 8'h14;
		wr(REG_SH_CTRL, 32'h0d);
		ev(0, 29'h123);
		chk("req_b", tx_req_b, 1'h1);
		chk("req_a", tx_req_a | tx_remote, 1'h0);
		chk("tx_id", tx_identifier, 29'h123);
		chk("irq", irq_pending, 1'h0);
		ev(0, 29'h456);
		chk("tx_id", tx_identifier, 29'h123);
		idle_state(2'h0);
	endtask
	task automatic t_remote;
		rst();
		dly <= 8'h2;
		wr(REG_SH_CTRL, 32'h60d);
		ev(2, 29'h55);
		chk("req_a", tx_req_a, 1'h1);
		idle_state(2'h2);
		ev(1, 29'h55);
		chk("req_b", tx_req_b, 1'h1);
		chk("remote", tx_remote, 1'h1);
		idle_state(2'h0);
	endtask
	task automatic t_answer;
		rst();
		wr(REG_SH_CTRL, 32'h10005);
		ev(0, 29'h2a);
		chk("req_b", tx_req_b, 1'h0);
		chk("irq", irq_pending, 1'h1);
		ev(3, 29'h2a);
		chk("req_b", tx_req_b, 1'h1);
		chk("remote", tx_remote, 1'h0);
		chk("tx_data", tx_data, 64'h2a);
		idle_state(2'h0);
		wr(REG_SH_CTRL, 32'h400005);
		chk("irq", irq_pending, 1'h0);
	endtask
	task automatic t_lost;
		rst();
		wr(REG_SH_CTRL, 32'h8000d);
		ev(0, 29'h31);
		chk("req_b", tx_req_b, 1'h0);
		wr(REG_SH_CTRL, 32'h100d);
		chk("req_b", tx_req_b, 1'h1);
		idle_state(2'h0);
	endtask
	initial begin
		rst();
		t_fifo();
		t_auto();
		t_remote();
		t_answer();
		t_lost();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		report_and_stop();
	end
endmodule // tb
